// >>> rtl/dcr_top.sv
// Duty-cycled receive controller with option store and AHB-Lite registers
// How it works
// - Boot into duty-cycle or continuous, continuous default
// - Sleep timer enable bit, default off
// - Sleep time 3 to 134152192 ms
// - Receive timer enable bit, default off
// - Receive window 0.04 ms up, default 2000
// - Extended window used only with wake-on-radio
// - Early exit goes to standby or tuned
// - Wake-on-radio enable gates condition and code
// - Six wake conditions, extend or switch
// - Duty-cycling accepts only switch conditions
// - Eight-bit match code for types 3, 6
// - Data rate 0.1 to 40 kbps
// - Frequency 300 to 920 MHz, kHz steps
// - AGC switchable, OOK demodulation only
// - Sleep timed by 1 kHz oscillator
`timescale 1ns/1ps
`include "dcr_params.svh"
module dcr_top #(
  parameter int LPO_CYC = `DCR_LPO_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_q,
  output logic hreadyout_q,
  output logic hresp_q,
  input wire logic rssi_hit,
  input wire logic preamble_hit,
  input wire logic rx_byte_vld,
  input wire logic [7:0] rx_byte,
  input wire logic rx_exit_req,
  output logic rx_on_q,
  output logic sleep_q,
  output logic standby_state_q,
  output logic tune_q,
  output logic low_power_oscillator_en_q,
  output logic agc_en_q,
  output logic [8:0] data_rate_q,
  output logic [19:0] freq_q
);
  localparam logic [11:0] RX_UNIT_CYC = 12'(`DCR_RX_UNIT_CYC);

  function automatic logic [31:0] clampv(input logic [31:0] v,
      input logic [31:0] lo, input logic [31:0] hi);
    clampv = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clampv

  function automatic logic [31:0] fix_cfg(input logic [2:0] idx,
      input logic [31:0] v);
    unique case (idx)
      `DCR_IDX_SLEEP: fix_cfg = clampv(v, `DCR_SLEEP_MIN,
                                       `DCR_SLEEP_MAX);
      `DCR_IDX_RXT, `DCR_IDX_RXEXT: fix_cfg = clampv(v, `DCR_RXT_MIN,
                                       `DCR_RXT_MAX);
      `DCR_IDX_RATE: fix_cfg = clampv(v, `DCR_RATE_MIN,
                                      `DCR_RATE_MAX);
      `DCR_IDX_FREQ: fix_cfg = clampv(v, `DCR_FREQ_MIN,
                                      `DCR_FREQ_MAX);
      default: fix_cfg = {15'h0000, v[16:0]};
    endcase
  endfunction : fix_cfg

  function automatic logic [31:0] dflt(input logic [2:0] idx);
    unique case (idx)
      `DCR_IDX_SLEEP: dflt = `DCR_RST_SLEEP;
      `DCR_IDX_RXT: dflt = `DCR_RST_RXT;
      `DCR_IDX_RXEXT: dflt = `DCR_RST_RXEXT;
      `DCR_IDX_RATE: dflt = `DCR_RST_RATE;
      `DCR_IDX_FREQ: dflt = `DCR_RST_FREQ;
      default: dflt = `DCR_RST_CTRL;
    endcase
  endfunction : dflt

  dcr_pkg::dcr_state_e st_q, st_d;
  logic [31:0] cfg_q [0:5];
  logic wr_pend_q;
  logic [2:0] wr_idx_q;
  logic [2:0] load_idx_q;
  logic [31:0] nvm_rdata;
  logic nvm_prog;
  logic [31:0] wr_val;
  logic nvm_we;
  logic reload;
  logic load_done;
  logic [11:0] unit_cnt_q;
  logic [17:0] lpo_cnt_q;
  logic unit_tick, lpo_tick;
  dcr_pkg::dcr_time_t cnt_q;
  logic [2:0] cond;
  logic cfg_duty, cfg_sleep_en, cfg_rx_en, cfg_tune, cfg_wor;
  logic duty_act, trig, code_hit, extend, switch_ext;
  logic sleep_done, win_done, ext_done, in_rx;
  dcr_pkg::dcr_state_e exit_st;
  logic [2:0] acc_idx;
  logic acc_ok;

  assign cfg_duty = cfg_q[0][`DCR_B_DUTY];
  assign cfg_sleep_en = cfg_q[0][`DCR_B_SLEEP_EN];
  assign cfg_rx_en = cfg_q[0][`DCR_B_RX_EN];
  assign cfg_tune = cfg_q[0][`DCR_B_TUNE];
  assign cfg_wor = cfg_q[0][`DCR_B_WOR];
  assign cond = cfg_q[0][`DCR_F_COND_HI:`DCR_F_COND_LO];

  // AHB-Lite slave: zero wait states, always OKAY
  assign acc_ok = hsel && htrans[1] && hready;
  assign acc_idx = haddr[4:2];
  assign reload = wr_pend_q && wr_idx_q == `DCR_IDX_CMD &&
                  hwdata[`DCR_B_RELOAD];
  assign wr_val = fix_cfg(wr_idx_q, hwdata);
  assign nvm_we = wr_pend_q && wr_idx_q < `DCR_CFG_WORDS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 3'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= acc_ok && hwrite && haddr[31:5] == 27'h000_0000;
      wr_idx_q <= acc_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      hrdata_q <= 32'h0000_0000;
      if (haddr[31:5] == 27'h000_0000) begin
        if (acc_idx < `DCR_CFG_WORDS) begin
          hrdata_q <= cfg_q[acc_idx];
        end else if (acc_idx == `DCR_IDX_STAT) begin
          hrdata_q <= {23'h00_0000, 1'b1, 1'b0, st_q};
        end
      end
    end
  end

  // Option store; software writes program it and the live copy
  dcr_nvm u_nvm (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(nvm_we),
    .waddr(wr_idx_q),
    .wdata(wr_val),
    .raddr(load_idx_q),
    .rdata_q(nvm_rdata),
    .rprog_q(nvm_prog)
  );

  assign load_done = st_q == dcr_pkg::DCR_LOAD &&
                     load_idx_q == `DCR_CFG_WORDS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_idx_q <= 3'h0;
    end else if (reload) begin
      load_idx_q <= 3'h0;
    end else if (st_q == dcr_pkg::DCR_LOAD &&
                 load_idx_q != `DCR_CFG_WORDS) begin
      load_idx_q <= load_idx_q + 3'h1;
    end
  end

  // Store read data lags its address by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) begin
        cfg_q[i] <= dflt(3'(i));
      end
    end else if (st_q == dcr_pkg::DCR_LOAD && load_idx_q != 3'h0 &&
                 nvm_prog) begin
      cfg_q[load_idx_q - 3'h1] <= nvm_rdata;
    end else if (nvm_we) begin
      cfg_q[wr_idx_q] <= wr_val;
    end
  end

  // Timebases: 10 us receive unit and 1 ms oscillator tick
  assign unit_tick = unit_cnt_q == RX_UNIT_CYC - 12'h001;
  assign lpo_tick = cfg_sleep_en && lpo_cnt_q == 18'(LPO_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_cnt_q <= 12'h000;
    end else begin
      unit_cnt_q <= unit_tick ? 12'h000 : unit_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpo_cnt_q <= 18'h0_0000;
    end else if (!cfg_sleep_en || lpo_tick) begin
      lpo_cnt_q <= 18'h0_0000;
    end else begin
      lpo_cnt_q <= lpo_cnt_q + 18'h0_0001;
    end
  end

  // Wake-on-radio triggers
  assign duty_act = cfg_duty && cfg_sleep_en;
  assign code_hit = rx_byte_vld &&
      rx_byte == cfg_q[0][`DCR_F_CODE_HI:`DCR_F_CODE_LO];
  always_comb begin
    unique case (cond)
      3'h1, 3'h4: trig = rssi_hit;
      3'h2, 3'h5: trig = preamble_hit;
      3'h3, 3'h6: trig = code_hit;
      default: trig = 1'b0;
    endcase
  end
  assign extend = cfg_wor && trig && cond <= 3'h3 && !duty_act &&
      st_q == dcr_pkg::DCR_RXWIN;
  assign switch_ext = cfg_wor && trig && cond >= 3'h4 &&
      st_q == dcr_pkg::DCR_RXWIN;

  assign sleep_done = lpo_tick &&
      {3'h0, cnt_q} + 32'h0000_0001 >= cfg_q[1];
  assign win_done = cfg_rx_en && unit_tick &&
      {3'h0, cnt_q} + 32'h0000_0001 >= cfg_q[2];
  assign ext_done = cfg_rx_en && unit_tick &&
      {3'h0, cnt_q} + 32'h0000_0001 >= cfg_q[3];
  assign exit_st = cfg_tune ? dcr_pkg::DCR_TUNE :
                              dcr_pkg::DCR_STANDBY;
  assign in_rx = st_q == dcr_pkg::DCR_RX || st_q == dcr_pkg::DCR_RXWIN ||
                 st_q == dcr_pkg::DCR_RXEXT;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      dcr_pkg::DCR_LOAD: begin
        if (load_done) begin
          st_d = !cfg_duty ? dcr_pkg::DCR_RX :
                 cfg_sleep_en ? dcr_pkg::DCR_SLEEP :
                 dcr_pkg::DCR_RXWIN;
        end
      end
      dcr_pkg::DCR_RX: begin
        if (rx_exit_req) begin
          st_d = exit_st;
        end
      end
      dcr_pkg::DCR_SLEEP: begin
        if (sleep_done) begin
          st_d = dcr_pkg::DCR_RXWIN;
        end
      end
      dcr_pkg::DCR_RXWIN: begin
        if (rx_exit_req) begin
          st_d = exit_st;
        end else if (switch_ext) begin
          st_d = dcr_pkg::DCR_RXEXT;
        end else if (win_done && !extend) begin
          st_d = duty_act ? dcr_pkg::DCR_SLEEP : exit_st;
        end
      end
      dcr_pkg::DCR_RXEXT: begin
        if (rx_exit_req) begin
          st_d = exit_st;
        end else if (ext_done) begin
          st_d = duty_act ? dcr_pkg::DCR_SLEEP : exit_st;
        end
      end
      dcr_pkg::DCR_STANDBY, dcr_pkg::DCR_TUNE: st_d = st_q;
      default: st_d = dcr_pkg::DCR_LOAD;
    endcase
    if (reload) begin
      st_d = dcr_pkg::DCR_LOAD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= dcr_pkg::DCR_LOAD;
    end else begin
      st_q <= st_d;
    end
  end

  // Window timer restarts on entry and on an extend trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (st_d != st_q || extend) begin
      cnt_q <= '0;
    end else if (st_q == dcr_pkg::DCR_SLEEP ? lpo_tick : unit_tick) begin
      cnt_q <= cnt_q + 29'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_on_q <= 1'b0;
      sleep_q <= 1'b0;
      standby_state_q <= 1'b0;
      tune_q <= 1'b0;
      low_power_oscillator_en_q <= 1'b0;
      agc_en_q <= 1'b0;
      data_rate_q <= 9'h000;
      freq_q <= 20'h0_0000;
    end else begin
      rx_on_q <= st_d == dcr_pkg::DCR_RX || st_d == dcr_pkg::DCR_RXWIN ||
                 st_d == dcr_pkg::DCR_RXEXT;
      sleep_q <= st_d == dcr_pkg::DCR_SLEEP;
      standby_state_q <= st_d == dcr_pkg::DCR_STANDBY;
      tune_q <= st_d == dcr_pkg::DCR_TUNE;
      low_power_oscillator_en_q <= cfg_sleep_en;
      agc_en_q <= cfg_q[0][`DCR_B_AGC];
      data_rate_q <= cfg_q[4][8:0];
      freq_q <= cfg_q[5][19:0];
    end
  end

  a_boot_cont: assert property (@(posedge hclk) disable iff (!hresetn)
    load_done && !cfg_duty && !reload |=> st_q == dcr_pkg::DCR_RX && rx_on_q)
    else $error("boot did not enter continuous receive");
  a_sleep_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q == dcr_pkg::DCR_SLEEP) |-> $past(cfg_sleep_en))
    else $error("sleep entered with sleep timer off");
  a_sleep_end: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == dcr_pkg::DCR_SLEEP && sleep_done && !reload
    |=> st_q == dcr_pkg::DCR_RXWIN && rx_on_q)
    else $error("sleep did not end in receive window");
  a_rx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == dcr_pkg::DCR_RXWIN && !cfg_rx_en && !rx_exit_req &&
    !switch_ext && !reload |=> st_q == dcr_pkg::DCR_RXWIN)
    else $error("window ended with receive timer off");
  a_ext_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q == dcr_pkg::DCR_RXEXT) |-> $past(cfg_wor) && $past(cond) >= 4)
    else $error("extended window without wake-on-radio");
  a_exit_target: assert property (@(posedge hclk) disable iff (!hresetn)
    in_rx && rx_exit_req && !reload |=> (cfg_tune ? tune_q : standby_state_q))
    else $error("early exit went to wrong state");
  a_no_extend: assert property (@(posedge hclk) disable iff (!hresetn)
    extend |-> cfg_wor && !duty_act && cond inside {[1:3]})
    else $error("extend while duty-cycling or disabled");
  a_rate_range: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_q[4] >= `DCR_RATE_MIN && cfg_q[4] <= `DCR_RATE_MAX)
    else $error("data rate out of range");
  a_alternate: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == dcr_pkg::DCR_RXWIN && win_done && duty_act && !extend &&
    !switch_ext && !rx_exit_req && !reload |=> sleep_q)
    else $error("window end did not return to sleep");
  c_sleep_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    st_q == dcr_pkg::DCR_SLEEP ##1 st_q == dcr_pkg::DCR_RXWIN);
  c_switch_ext: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q == dcr_pkg::DCR_RXEXT));
  c_exit_tune: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(tune_q));
endmodule : dcr_top

// >>> include/dcr_params.svh
// Offsets, reset values, ranges and timing counts of the receive controller
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH
`define DCR_IDX_CTRL 3'h0
`define DCR_IDX_SLEEP 3'h1
`define DCR_IDX_RXT 3'h2
`define DCR_IDX_RXEXT 3'h3
`define DCR_IDX_RATE 3'h4
`define DCR_IDX_FREQ 3'h5
`define DCR_IDX_CMD 3'h6
`define DCR_IDX_STAT 3'h7
`define DCR_CFG_WORDS 3'h6
`define DCR_B_DUTY 0
`define DCR_B_SLEEP_EN 1
`define DCR_B_RX_EN 2
`define DCR_B_TUNE 3
`define DCR_B_WOR 4
`define DCR_F_COND_LO 5
`define DCR_F_COND_HI 7
`define DCR_F_CODE_LO 8
`define DCR_F_CODE_HI 15
`define DCR_B_AGC 16
`define DCR_B_RELOAD 0
`define DCR_B_OOK 8
`define DCR_RST_CTRL 32'h0001_0040
`define DCR_RST_SLEEP 32'h0000_0003
`define DCR_RST_RXT 32'h0003_0d40
`define DCR_RST_RXEXT 32'h0000_4e20
`define DCR_RST_RATE 32'h0000_0018
`define DCR_RST_FREQ 32'h000d_3ea0
`define DCR_SLEEP_MIN 32'h0000_0003
`define DCR_SLEEP_MAX 32'h07ff_0000
`define DCR_RXT_MIN 32'h0000_0004
`define DCR_RXT_MAX 32'h0ffd_ffac
`define DCR_RATE_MIN 32'h0000_0001
`define DCR_RATE_MAX 32'h0000_0190
`define DCR_FREQ_MIN 32'h0004_93e0
`define DCR_FREQ_MAX 32'h000e_09c0
`define DCR_CLK_PS 4000
`define DCR_RX_UNIT_PS 10000000
`define DCR_RX_UNIT_CYC (`DCR_RX_UNIT_PS / `DCR_CLK_PS)
`define DCR_LPO_PERIOD_PS 1000000000
`define DCR_LPO_CYC (`DCR_LPO_PERIOD_PS / `DCR_CLK_PS)
`endif

// >>> include/dcr_pkg.sv
// Types of the receive controller
package dcr_pkg;
  typedef enum logic [6:0] {
    DCR_LOAD = 7'b000_0001,
    DCR_RX = 7'b000_0010,
    DCR_SLEEP = 7'b000_0100,
    DCR_RXWIN = 7'b000_1000,
    DCR_RXEXT = 7'b001_0000,
    DCR_STANDBY = 7'b010_0000,
    DCR_TUNE = 7'b100_0000
  } dcr_state_e;
  typedef logic [28:0] dcr_time_t;
endpackage : dcr_pkg

// >>> rtl/dcr_nvm.sv
// Small option store with registered read data and per-word programmed flag
`timescale 1ns/1ps
module dcr_nvm (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [2:0] raddr,
  output logic [31:0] rdata_q,
  output logic rprog_q
);
  logic [31:0] mem [0:7];
  logic [7:0] prog_q;

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

  // A blank word keeps the controller on its factory value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_q <= 8'h00;
      rprog_q <= 1'b0;
    end else begin
      if (we) begin
        prog_q[waddr] <= 1'b1;
      end
      rprog_q <= prog_q[raddr];
    end
  end
endmodule : dcr_nvm

// >>> sim/dcr_ook_tx.sv
// Behavioural model of the remote on-off keyed transmitter's receive events
`timescale 1ns/1ps
module dcr_ook_tx (
  input wire logic hclk,
  output logic rssi_hit,
  output logic preamble_hit,
  output logic rx_byte_vld,
  output logic [7:0] rx_byte
);
  logic [7:0] byte_q = 8'h00;
  logic [7:0] idle_q = 8'h00;
  // Between bytes the data lines wander so a stale byte never matches
  always @(posedge hclk) idle_q <= idle_q + 8'h3b;
  assign rx_byte = rx_byte_vld ? byte_q : idle_q;
  initial begin
    rssi_hit = 1'b0;
    preamble_hit = 1'b0;
    rx_byte_vld = 1'b0;
  end
  // One trigger of the given kind, after a gap of idle cycles
  task pulse(input int kind, input logic [7:0] b, input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    case (kind)
      0: rssi_hit <= 1'b1;
      1: preamble_hit <= 1'b1;
      default: begin
        byte_q <= b;
        rx_byte_vld <= 1'b1;
      end
    endcase
    @(posedge hclk);
    rssi_hit <= 1'b0;
    preamble_hit <= 1'b0;
    rx_byte_vld <= 1'b0;
  endtask : pulse
endmodule : dcr_ook_tx

// >>> sim/testbench.sv
// Self-checking testbench of the duty-cycled receive controller
`timescale 1ns/1ps
`include "dcr_params.svh"
module testbench;
  localparam int LPO = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rx_exit_req = 1'b0;
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q, rx_on_q, sleep_q, standby_state_q, tune_q;
  logic lpo_en, agc_en_q, rssi_hit, preamble_hit, rx_byte_vld;
  logic [7:0] rx_byte;
  logic [8:0] data_rate_q;
  logic [19:0] freq_q;
  logic [3:0] st;
  logic [31:0] rd, v;
  int error_cnt = 0;
  int samples_checked = 0;
  int n, k;
  logic [31:0] dflt [6] = '{`DCR_RST_CTRL, `DCR_RST_SLEEP, `DCR_RST_RXT,
    `DCR_RST_RXEXT, `DCR_RST_RATE, `DCR_RST_FREQ};
  logic [31:0] lo [6] = '{32'h0000_0000, `DCR_SLEEP_MIN, `DCR_RXT_MIN,
    `DCR_RXT_MIN, `DCR_RATE_MIN, `DCR_FREQ_MIN};
  logic [31:0] hi [6] = '{32'hffff_ffff, `DCR_SLEEP_MAX, `DCR_RXT_MAX,
    `DCR_RXT_MAX, `DCR_RATE_MAX, `DCR_FREQ_MAX};
  // Wake cases: control word, trigger kind, byte, expected status
  logic [31:0] wctl [6] = '{32'h0001_00b7,
    32'h0001_0057,
    32'h0001_5ad7,
    32'h0001_5ad7, 32'h0001_0097,
    32'h0001_00a7};
  int wkind [6] = '{1, 1, 2, 2, 0, 1};
  logic [7:0] wbyte [6] = '{8'h00, 8'h00, 8'ha5, 8'h5a, 8'h00, 8'h00};
  logic [31:0] wexp [6] = '{32'h0000_0110, 32'h0000_0108, 32'h0000_0108,
    32'h0000_0110, 32'h0000_0110, 32'h0000_0108};
  assign st = {standby_state_q, tune_q, rx_on_q, sleep_q};
  always #2 hclk = ~hclk;
  dcr_top #(.LPO_CYC(LPO)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
    .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
    .rssi_hit(rssi_hit), .preamble_hit(preamble_hit),
    .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte),
    .rx_exit_req(rx_exit_req), .rx_on_q(rx_on_q), .sleep_q(sleep_q),
    .standby_state_q(standby_state_q), .tune_q(tune_q),
    .low_power_oscillator_en_q(lpo_en), .agc_en_q(agc_en_q),
    .data_rate_q(data_rate_q), .freq_q(freq_q));
  dcr_ook_tx tx (.hclk(hclk), .rssi_hit(rssi_hit),
    .preamble_hit(preamble_hit), .rx_byte_vld(rx_byte_vld),
    .rx_byte(rx_byte));
  function automatic logic [31:0] clampv(input logic [31:0] x,
      input logic [31:0] l, input logic [31:0] h);
    return x < l ? l : (x > h ? h : x);
  endfunction : clampv
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout_q !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout_q !== 1'b1);
    rd = hrdata_q;
  endtask : ahb
  // Waits for one state output, with a cycle limit
  task wait_on(input int which, input int lim);
    n = 0;
    while (n <= lim && st[which] !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    if (n > lim) chk(32'h0000_0001, 32'h0000_0000);
  endtask : wait_on
  task exitp;
    @(posedge hclk);
    rx_exit_req <= 1'b1;
    @(posedge hclk);
    rx_exit_req <= 1'b0;
  endtask : exitp
  task results;
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (99000) @(posedge hclk);
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(32'hc2cf));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
    chk(32'(rx_on_q), 32'h0000_0001);
    chk(32'(lpo_en), 32'h0000_0000);
    chk(32'(agc_en_q), 32'h0000_0001);
    chk(32'(data_rate_q), `DCR_RST_RATE);
    chk(32'(freq_q), `DCR_RST_FREQ);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, 32'(i * 4), 32'h0000_0000);
      chk(rd, dflt[i]);
    end
    ahb(1'b0, 32'h0000_001c, 32'h0000_0000);
    chk(rd, 32'h0000_0102);
    ahb(1'b1, 32'h0000_0040, 32'hffff_ffff);
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(hresp_q), 32'h0000_0000);
    for (int i = 0; i < 20; i++) begin
      k = 1 + i % 5;
      v = i < 5 ? 32'h0000_0000 : (i < 10 ? 32'hffff_ffff :
        $urandom() >> $urandom_range(31, 0));
      ahb(1'b1, 32'(k * 4), v);
      ahb(1'b0, 32'(k * 4), 32'h0000_0000);
      chk(rd, clampv(v, lo[k], hi[k]));
    end
    ahb(1'b1, 32'h0000_0010, `DCR_RATE_MAX);
    ahb(1'b1, 32'h0000_0014, `DCR_FREQ_MAX);
    repeat (2) @(posedge hclk);
    chk(32'(data_rate_q), `DCR_RATE_MAX);
    chk(32'(freq_q), `DCR_FREQ_MAX);
    ahb(1'b1, 32'h0000_0000, 32'h0001_0008);
    exitp();
    wait_on(2, 4);
    ahb(1'b1, 32'h0000_0000, 32'h0001_0000);
    ahb(1'b1, 32'h0000_0018, 32'h0000_0001);
    wait_on(1, 20);
    exitp();
    wait_on(3, 4);
    ahb(1'b1, 32'h0000_0004, 32'h0000_0003);
    ahb(1'b1, 32'h0000_0008, 32'h0000_0004);
    ahb(1'b1, 32'h0000_000c, 32'h0000_0004);
    ahb(1'b1, 32'h0000_0000, 32'h0001_0031);
    ahb(1'b1, 32'h0000_0018, 32'h0000_0001);
    wait_on(1, 20);
    tx.pulse(0, 8'h00, $urandom_range(3, 0));
    repeat (10010) @(posedge hclk);
    ahb(1'b0, 32'h0000_001c, 32'h0000_0000);
    chk(rd, 32'h0000_0108);
    exitp();
    wait_on(3, 4);
    ahb(1'b1, 32'h0000_0000, 32'h0001_00b7);
    ahb(1'b1, 32'h0000_0018, 32'h0000_0001);
    wait_on(0, 20);
    chk(32'(lpo_en), 32'h0000_0001);
    wait_on(1, 3 * LPO + 4);
    chk(32'(n >= 2 * LPO), 32'h0000_0001);
    ahb(1'b0, 32'h0000_001c, 32'h0000_0000);
    chk(rd, 32'h0000_0108);
    wait_on(0, 10010);
    chk(32'(n >= 7490), 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, 32'h0000_0000, wctl[i]);
      wait_on(0, 10010);
      wait_on(1, 3 * LPO + 4);
      tx.pulse(wkind[i], wbyte[i], $urandom_range(3, 0));
      repeat (3) @(posedge hclk);
      ahb(1'b0, 32'h0000_001c, 32'h0000_0000);
      chk(rd, wexp[i]);
    end
    wait_on(0, 10010);
    results();
  end
endmodule : testbench
